// ==== rtl/lnm_map.vh ====
// Constants for the node mode and wake controller.
`ifndef LNM_MAP_VH
`define LNM_MAP_VH
`define LNM_CLK_MHZ        125
`define LNM_MODE_W         3
`define LNM_MODE_UNPOWERED 3'h0
`define LNM_MODE_FAILSAFE  3'h1
`define LNM_MODE_NORMAL    3'h2
`define LNM_MODE_SILENT    3'h3
`define LNM_MODE_SLEEP     3'h4
`define LNM_RESET_MS       4
`define LNM_DOM_TIMEOUT_MS 6
`define LNM_STUCK_TXD_MS   20
`define LNM_WAKE_REARM_US  10
`define LNM_IGN_REARM_US   250
`define LNM_BUS_FILT_US    100
`define LNM_WAKE_FILT_US   50
`define LNM_IGN_FILT_US    160
`define LNM_RESET_CYC      (`LNM_RESET_MS * 1000 * `LNM_CLK_MHZ)
`define LNM_DOM_CYC        (`LNM_DOM_TIMEOUT_MS * 1000 * `LNM_CLK_MHZ)
`define LNM_STUCK_CYC      (`LNM_STUCK_TXD_MS * 1000 * `LNM_CLK_MHZ)
`define LNM_WREARM_CYC     (`LNM_WAKE_REARM_US * `LNM_CLK_MHZ)
`define LNM_IREARM_CYC     (`LNM_IGN_REARM_US * `LNM_CLK_MHZ)
`define LNM_BUS_CYC        (`LNM_BUS_FILT_US * `LNM_CLK_MHZ)
`define LNM_WAKE_CYC       (`LNM_WAKE_FILT_US * `LNM_CLK_MHZ)
`define LNM_IGN_CYC        (`LNM_IGN_FILT_US * `LNM_CLK_MHZ)
`endif

// ==== rtl/lnm_mode_ctrl.v ====
// Operating-mode and wake controller of a bus node basis chip.
// Function
// - Normal keeps transceiver on; reset low gives fail-safe.
// - Enable fall with transmit high enters silent.
// - Silent disables transmit and termination; weak pull-up.
// - Silent/sleep entry ignores bus and wake pin levels.
// - Silent undervoltage pulls reset low, fail-safe.
// - Filtered bus dominant pulse gives remote wake.
// - After remote wake, enable high gives normal.
// - Enable fall with transmit low enters sleep.
// - Sleep: regulator, inhibit off; reset, receive low.
// - Power-up: fail-safe, reset low 4ms, link off.
// - Fail-safe held until enable high, then normal.
// - Battery undervoltage in silent/sleep gives fail-safe.
// - Any reset-low outside unpowered moves directly to fail-safe.
// - Supply good leaves unpowered; no change during reset.
// - Bus low in normal arms wake on next rise.
// - Filtered wake pin low gives local wake.
// - Wake pin rearms after high over 10us.
// - Filtered ignition high gives local wake.
// - Ignition rearms after low over 250us.
// - Fail-safe transmit shows last wake source.
// - Flags clear on normal entry; source kept.
// - Stuck-low transmit allows sleep at once; no 20ms wait.
// - Normal passes transmit to bus, bus to receive.
// - Transmit low over 6ms forces bus recessive.
`timescale 1ns/1ns
`include "lnm_map.vh"
// The controller runs from the single system clock, so every filter, rearm
// and timeout below is a plain cycle counter compared with a parameter.
// The defaults reproduce the nominal times at 125 MHz; a bench may shrink
// them to keep runs short without touching any of the logic.
// Mode codes are shared with the outside through the constants header so
// that a host model or monitor decodes the same values as the mode output.
module lnm_mode_ctrl #(
    // Filter and timeout lengths in clock cycles.
    parameter RESET_CYC  = `LNM_RESET_CYC,
    parameter DOM_CYC    = `LNM_DOM_CYC,
    parameter STUCK_CYC  = `LNM_STUCK_CYC,
    parameter WREARM_CYC = `LNM_WREARM_CYC,
    parameter IREARM_CYC = `LNM_IREARM_CYC,
    parameter BUS_CYC    = `LNM_BUS_CYC,
    parameter WAKE_CYC   = `LNM_WAKE_CYC,
    parameter IGN_CYC    = `LNM_IGN_CYC
) (
    // Clock and reset.
    input  wire                   clock,
    input  wire                   rst,
    // Supply monitors.
    input  wire                   battery_supply_ok,
    input  wire                   vcc_undervoltage,
    input  wire                   watchdog_fault,
    // Host pins.
    input  wire                   enable_in,
    input  wire                   txd_in,
    output reg                    txd_out,
    output reg                    txd_oe_n,
    output reg                    rxd_out,
    output reg                    reset_out_n,
    // Bus and wake pins.
    input  wire                   bus_level,
    input  wire                   local_wake_in,
    input  wire                   ignition_wake_input,
    output reg                    bus_drive_dominant,
    output reg                    bus_termination_on,
    output reg                    bus_weak_pullup_on,
    // Supply control and status.
    output reg                    regulator_on,
    output reg                    regulator_inhibit_out,
    output reg                    undervoltage_det_on,
    output reg  [`LNM_MODE_W-1:0] mode_out
);
    localparam [2:0] UNP = `LNM_MODE_UNPOWERED;
    localparam [2:0] FSF = `LNM_MODE_FAILSAFE;
    localparam [2:0] NRM = `LNM_MODE_NORMAL;
    localparam [2:0] SIL = `LNM_MODE_SILENT;
    localparam [2:0] SLP = `LNM_MODE_SLEEP;
    localparam [31:0] ONE = 32'h00000001;

    reg [2:0]  mode_q, mode_d;
    reg [31:0] rst_cnt_q, dom_cnt_q, bus_cnt_q, wk_cnt_q, ig_cnt_q, wr_cnt_q, ir_cnt_q;
    reg        en_q, bus_q;
    reg        bus_armed_q, wk_armed_q, ig_armed_q, dom_block_q;
    reg        wake_flag_q, src_local_q;
    wire       en_fall  = en_q & ~enable_in;
    wire       bus_rise = ~bus_q & bus_level;
    wire       rst_low  = (rst_cnt_q != 32'h0) | vcc_undervoltage | watchdog_fault;
    wire       low_power = (mode_q == SIL) | (mode_q == SLP);
    wire       bus_wake = low_power & bus_armed_q & bus_rise;
    wire       wk_wake  = low_power & wk_armed_q & (wk_cnt_q >= WAKE_CYC);
    wire       ig_wake  = low_power & ig_armed_q & (ig_cnt_q >= IGN_CYC);
    // A stuck-low transmit counts as low at once; the pin alone decides, with no timeout.
    wire       tx_low   = ~txd_in;
    // Events that restart the reset pulse in this cycle.
    wire       rst_load = (mode_q == UNP && battery_supply_ok) ||
                          (mode_q == SIL && ~battery_supply_ok) || vcc_undervoltage;
    // Next values of the wake flags, so the pins show a wake on the edge that enters fail-safe.
    wire       wake_any = bus_wake | wk_wake | ig_wake;
    wire       flag_d   = wake_any | (wake_flag_q & (mode_d != NRM));
    wire       src_d    = wake_any ? (wk_wake | ig_wake) : src_local_q;

    // Edge history of the input pins.
    always @(posedge clock) begin
        if (rst) begin
            en_q <= 1'b0;
            bus_q <= 1'b1;
        end else begin
            en_q <= enable_in;
            bus_q <= bus_level;
        end
    end

    // Reset pulse: restarts on power-up, on undervoltage and on a battery drop in silent.
    always @(posedge clock) begin
        if (rst) begin
            rst_cnt_q <= 32'h0;
        end else if (mode_q == UNP && battery_supply_ok) begin
            rst_cnt_q <= RESET_CYC;
        end else if ((mode_q == SIL && ~battery_supply_ok) || vcc_undervoltage) begin
            rst_cnt_q <= RESET_CYC;
        end else if (rst_cnt_q != 32'h0) begin
            rst_cnt_q <= rst_cnt_q - ONE;
        end
    end

    // Dominant timeout on transmit; the low time saturates at STUCK_CYC and does not gate sleep.
    always @(posedge clock) begin
        if (rst) begin
            dom_cnt_q <= 32'h0;
            dom_block_q <= 1'b0;
        end else if (txd_in) begin
            dom_cnt_q <= 32'h0;
            dom_block_q <= 1'b0;
        end else begin
            if (dom_cnt_q < STUCK_CYC)
                dom_cnt_q <= dom_cnt_q + ONE;
            if (dom_cnt_q >= DOM_CYC)
                dom_block_q <= 1'b1;
        end
    end

    // Bus wake filter: runs in normal too so a dominant before sleep still wakes.
    always @(posedge clock) begin
        if (rst) begin
            bus_cnt_q <= 32'h0;
            bus_armed_q <= 1'b0;
        end else if (mode_q != NRM && !low_power) begin
            bus_cnt_q <= 32'h0;
            bus_armed_q <= 1'b0;
        end else if (!bus_level) begin
            if (bus_cnt_q < BUS_CYC)
                bus_cnt_q <= bus_cnt_q + ONE;
            else
                bus_armed_q <= 1'b1;
        end else begin
            bus_cnt_q <= 32'h0;
            bus_armed_q <= 1'b0;
        end
    end

    // Wake pin filter and rearm; a held-low pin does not block sleep entry.
    always @(posedge clock) begin
        if (rst) begin
            wk_cnt_q <= 32'h0;
            wr_cnt_q <= 32'h0;
            wk_armed_q <= 1'b0;
        end else if (local_wake_in) begin
            wk_cnt_q <= 32'h0;
            if (wr_cnt_q < WREARM_CYC)
                wr_cnt_q <= wr_cnt_q + ONE;
            else
                wk_armed_q <= 1'b1;
        end else begin
            wr_cnt_q <= 32'h0;
            if (wk_cnt_q < WAKE_CYC)
                wk_cnt_q <= wk_cnt_q + ONE;
            if (wk_wake)
                wk_armed_q <= 1'b0;
        end
    end

    // Ignition filter and rearm, mirrored polarity of the wake pin.
    always @(posedge clock) begin
        if (rst) begin
            ig_cnt_q <= 32'h0;
            ir_cnt_q <= 32'h0;
            ig_armed_q <= 1'b0;
        end else if (!ignition_wake_input) begin
            ig_cnt_q <= 32'h0;
            if (ir_cnt_q < IREARM_CYC)
                ir_cnt_q <= ir_cnt_q + ONE;
            else
                ig_armed_q <= 1'b1;
        end else begin
            ir_cnt_q <= 32'h0;
            if (ig_cnt_q < IGN_CYC)
                ig_cnt_q <= ig_cnt_q + ONE;
            if (ig_wake)
                ig_armed_q <= 1'b0;
        end
    end

    // Mode transitions; reset-low has priority over every host request.
    // Unpowered is left only once the battery monitor reports a good supply,
    // and the reset pulse started on that edge then blocks the enable input.
    // Fail-safe waits for enable high; a host that keeps enable low there
    // keeps the regulator running, which is the safe state after any fault.
    // Silent and sleep are entered on the enable fall whatever the bus and
    // wake pins show, so a held wake pin can never trap the node awake.
    // A stuck-low transmit pin therefore always leads to sleep on an enable
    // fall; the dominant timeout only keeps the bus driver recessive.
    // From silent and sleep every wake source and every supply fault lead to
    // fail-safe; sleep with a low battery does so without a new reset pulse.
    always @* begin
        mode_d = mode_q;
        case (mode_q)
            UNP: begin
                if (battery_supply_ok)
                    mode_d = FSF;
            end
            FSF: begin
                if (!rst_low && enable_in)
                    mode_d = NRM;
            end
            NRM: begin
                if (rst_low)
                    mode_d = FSF;
                else if (en_fall && txd_in)
                    mode_d = SIL;
                else if (en_fall && tx_low)
                    mode_d = SLP;
            end
            SIL, SLP: begin
                if (~battery_supply_ok || rst_low || bus_wake || wk_wake || ig_wake)
                    mode_d = FSF;
            end
            default: mode_d = FSF;
        endcase
        if (mode_q != UNP && rst_low)
            mode_d = FSF;
    end

    // Mode register and wake flags; a wake in the clearing cycle still sets.
    always @(posedge clock) begin
        if (rst) begin
            mode_q <= UNP;
            wake_flag_q <= 1'b0;
            src_local_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            wake_flag_q <= flag_d;
            src_local_q <= src_d;
        end
    end

    // Pin drivers, all registered from the next mode.
    // Working from the next mode and next flags means every pin changes on
    // the same edge as the mode output, with no one-cycle stale window.
    // The reset output also looks at the reload condition, otherwise it
    // would show a one-cycle high pulse on the edge that starts the pulse.
    // The transmit pin is only ever pulled low by the device; the high level
    // for a remote wake comes from the pull-up on the host side.
    // The receive pin follows the bus one cycle late in normal mode, which
    // is far below any bit time on the link.
    always @(posedge clock) begin
        if (rst) begin
            txd_out <= 1'b1;
            txd_oe_n <= 1'b1;
            rxd_out <= 1'b0;
            reset_out_n <= 1'b0;
            bus_drive_dominant <= 1'b0;
            bus_termination_on <= 1'b0;
            bus_weak_pullup_on <= 1'b0;
            regulator_on <= 1'b0;
            regulator_inhibit_out <= 1'b0;
            undervoltage_det_on <= 1'b0;
            mode_out <= UNP;
        end else begin
            mode_out <= mode_d;
            // Local source drives a strong low; remote leaves the weak pull-up high.
            txd_out <= 1'b0;
            txd_oe_n <= ~(mode_d == FSF && flag_d && src_d);
            rxd_out <= (mode_d == NRM) ? bus_level :
                       (mode_d == SLP) ? 1'b0 :
                       ~(mode_d == FSF && flag_d);
            reset_out_n <= ~(rst_low | rst_load | (mode_d == SLP) | (mode_d == UNP));
            bus_drive_dominant <= (mode_d == NRM) & ~txd_in & ~dom_block_q;
            bus_termination_on <= (mode_d == NRM) | (mode_d == FSF);
            bus_weak_pullup_on <= (mode_d == SIL) | (mode_d == SLP);
            regulator_on <= (mode_d != SLP) & (mode_d != UNP);
            regulator_inhibit_out <= ((mode_d == NRM) | (mode_d == FSF)) & ~vcc_undervoltage;
            undervoltage_det_on <= (mode_d != UNP);
        end
    end
endmodule // lnm_mode_ctrl

// ==== tb/lnm_host_model.sv ====
// Host controller model that drives the enable and transmit pins.
`timescale 1ns/1ns
module lnm_host_model (
    // Clock and request from the bench.
    input  wire       clock,
    input  wire [1:0] host_req,
    input  wire       tx_bit,
    // Pins towards the device.
    output reg        enable_in,
    output reg        host_txd
);
    // Requests: 0 released, 1 normal, 2 silent, 3 sleep; idle transmit floats high on its pull-up.
    initial {enable_in, host_txd} = 2'h1;
    // Both pins move on one edge, so transmit is settled inside the mode-select window.
    always @(posedge clock) begin
        case (host_req)
            2'h1: {enable_in, host_txd} <= {1'b1, tx_bit};
            2'h3: {enable_in, host_txd} <= 2'h0;
            default: {enable_in, host_txd} <= 2'h1;
        endcase
    end
endmodule // lnm_host_model

// ==== tb/lnm_mode_ctrl_sva.sv ====
// Port assertions for the node mode controller.
`timescale 1ns/1ns
module lnm_mode_sva #(
    parameter int RESET_CYC = 20
) (
    // Clock, reset and supplies.
    input wire       clock, rst, vcc_undervoltage, watchdog_fault,
    // Host and bus pins.
    input wire       enable_in, txd_in, bus_level, rxd_out, reset_out_n,
    // Supply and mode outputs.
    input wire       bus_termination_on, bus_weak_pullup_on, regulator_on, regulator_inhibit_out,
    input wire       undervoltage_det_on,
    input wire [2:0] mode_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    int unsigned cnt_q;
    logic        pu_q;
    // Length of the first reset pulse; a supply fault restarts the count.
    always @(posedge clock) begin
        cnt_q <= (rst || mode_out == 3'h0 || reset_out_n || vcc_undervoltage || watchdog_fault) ? 0 : cnt_q + 1;
        pu_q  <= (rst || mode_out == 3'h0) ? 1'b1 : (reset_out_n ? 1'b0 : pu_q);
    end
    sequence s_en_fall;
        $past(enable_in) && !enable_in;
    endsequence
    a_fall_silent: assert property (s_en_fall ##0 (txd_in && mode_out == 3'h2) |=> mode_out == 3'h3)
        else $error("silent entry missed");
    a_fall_sleep: assert property (s_en_fall ##0 (!txd_in && mode_out == 3'h2) |=> mode_out == 3'h4)
        else $error("sleep entry missed");
    a_sleep_outs: assert property (mode_out == 3'h4 |-> !(regulator_on || regulator_inhibit_out))
        else $error("sleep outputs wrong");
    a_sleep_pins: assert property (mode_out == 3'h4 |-> !reset_out_n && !rxd_out)
        else $error("sleep pins wrong");
    a_silent_outs: assert property (mode_out == 3'h3 |-> bus_weak_pullup_on && regulator_on)
        else $error("silent outputs wrong");
    a_normal_on: assert property (mode_out == 3'h2 |-> undervoltage_det_on && bus_termination_on)
        else $error("normal outputs wrong");
    a_uv_failsafe: assert property (mode_out == 3'h2 && vcc_undervoltage |-> ##[1:2] mode_out == 3'h1)
        else $error("undervoltage kept normal");
    a_fs_hold: assert property (mode_out == 3'h1 && !enable_in |=> mode_out inside {3'h0, 3'h1})
        else $error("fail-safe left without enable");
    a_fs_normal: assert property (mode_out == 3'h1 && enable_in && reset_out_n && !vcc_undervoltage |=> mode_out == 3'h2)
        else $error("enable did not give normal");
    a_rx_follow: assert property (mode_out == 3'h2 && $past(mode_out) == 3'h2 |-> rxd_out == $past(bus_level))
        else $error("receive pin not following bus");
    a_rst_width: assert property ($rose(reset_out_n) && pu_q |-> cnt_q inside {[RESET_CYC:RESET_CYC+2]})
        else $error("power-up reset width wrong");
endmodule // lnm_mode_sva
bind lnm_mode_ctrl lnm_mode_sva #(.RESET_CYC(RESET_CYC)) i_lnm_mode_sva (.clock, .rst, .vcc_undervoltage,
    .watchdog_fault, .enable_in, .txd_in, .bus_level, .rxd_out, .reset_out_n, .bus_termination_on,
    .bus_weak_pullup_on, .regulator_on, .regulator_inhibit_out, .undervoltage_det_on, .mode_out);

// ==== tb/tb_lnm_mode_ctrl.sv ====
// Self-checking bench for the node mode controller.
`timescale 1ns/1ns
module tb_lnm_mode_ctrl;
    localparam int rst_c = 20, dom_c = 30, bus_c = 6, wk_c = 6, wr_c = 5, ign_c = 10;
    logic       clock, rst, battery_supply_ok, vcc_undervoltage, watchdog_fault;
    logic       bus_level, local_wake_in, ignition_wake_input, tx_bit;
    logic [1:0] host_req;
    logic [2:0] last_mode = 3'h0;
    logic [4:0] exp_q[$];
    int         errors = 0, n_tests = 0;
    wire        enable_in, host_txd, txd_in, txd_out, txd_oe_n, rxd_out, reset_out_n, bus_drive_dominant;
    wire        bus_termination_on, bus_weak_pullup_on, regulator_on, regulator_inhibit_out, undervoltage_det_on;
    wire [2:0]  mode_out;
    // The transmit wire is pulled low by the device when its enable is low, else the host sets it.
    assign txd_in = txd_oe_n ? host_txd : txd_out;
    lnm_host_model i_lnm_host_model (.clock, .host_req, .tx_bit, .enable_in, .host_txd);
    lnm_mode_ctrl #(.RESET_CYC(rst_c), .DOM_CYC(dom_c), .STUCK_CYC(40), .WREARM_CYC(wr_c), .IREARM_CYC(8),
        .BUS_CYC(bus_c), .WAKE_CYC(wk_c), .IGN_CYC(ign_c)) i_lnm_mode_ctrl (.clock, .rst, .battery_supply_ok,
        .vcc_undervoltage, .watchdog_fault, .enable_in, .txd_in, .txd_out, .txd_oe_n, .rxd_out, .reset_out_n,
        .bus_level, .local_wake_in, .ignition_wake_input, .bus_drive_dominant, .bus_termination_on,
        .bus_weak_pullup_on, .regulator_on, .regulator_inhibit_out, .undervoltage_det_on, .mode_out);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic note(input logic [2:0] m, input logic r, input logic o);
        exp_q.push_back({m, r, o});
    endtask
    task automatic chk(input string what, input logic [4:0] e, input logic [4:0] s);
        n_tests++;
        if (e !== s) begin
            errors++;
            $display("CHECK FAILED %s: expected %h, seen %h", what, e, s);
        end
    endtask
    task automatic complete_run;
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Each mode change is compared with the oldest note of mode, receive pin and transmit pull-down.
    always @(negedge clock) begin
        if (!rst && mode_out !== last_mode) chk("mode", exp_q.size() ? exp_q.pop_front() : 5'h1F,
            {mode_out, rxd_out, txd_oe_n});
        last_mode = mode_out;
    end
    // A hang costs a mismatch; the tests need well under a thousand cycles.
    initial begin
        cyc(5000);
        errors++;
        complete_run;
    end
    initial begin
        void'($urandom(66));
        {rst, battery_supply_ok, vcc_undervoltage, watchdog_fault, tx_bit} = 5'h19;
        {bus_level, local_wake_in, ignition_wake_input, host_req} = 5'h18;
        cyc(6);
        rst <= 1'b0;
        host_req <= 2'h1;
        note(3'h1, 1'b1, 1'b1);
        note(3'h2, 1'b1, 1'b1);
        cyc(10);
        @(negedge clock);
        chk("pulse", 5'h05, {mode_out, reset_out_n, regulator_on});
        cyc(rst_c + 5);
        repeat (40) begin
            bus_level <= 1'($urandom);
            tx_bit <= 1'($urandom);
            cyc(1);
        end
        {bus_level, tx_bit} <= 2'h0;
        cyc(4);
        @(negedge clock);
        chk("driver", 5'h01, {4'h0, bus_drive_dominant});
        cyc(dom_c + 4);
        @(negedge clock);
        chk("timeout", 5'h00, {4'h0, bus_drive_dominant});
        tx_bit <= 1'b1;
        // Silent entry, bus wake, then enable straight back to normal.
        note(3'h3, 1'b1, 1'b1);
        note(3'h1, 1'b0, 1'b1);
        note(3'h2, 1'b1, 1'b1);
        host_req <= 2'h2;
        cyc(4);
        bus_level <= 1'b0;
        cyc(bus_c + 2);
        bus_level <= 1'b1;
        cyc(4);
        host_req <= 2'h1;
        cyc(4);
        // Sleep, then a wake pin press; a second sleep is entered with the pin already low and woken by a new press after the pin rearms.
        note(3'h4, 1'b0, 1'b1);
        note(3'h1, 1'b0, 1'b0);
        note(3'h2, 1'b1, 1'b1);
        note(3'h4, 1'b0, 1'b1);
        note(3'h1, 1'b0, 1'b0);
        note(3'h2, 1'b1, 1'b1);
        host_req <= 2'h3;
        cyc(4);
        local_wake_in <= 1'b0;
        cyc(wk_c + 3);
        {local_wake_in, host_req} <= 3'h5;
        cyc(4);
        {local_wake_in, host_req} <= 3'h3;
        cyc(wk_c + 10);
        local_wake_in <= 1'b1;
        cyc(wr_c + 2);
        local_wake_in <= 1'b0;
        cyc(wk_c + 3);
        {local_wake_in, host_req} <= 3'h5;
        cyc(4);
        // Ignition wake from sleep, then silent entry with ignition high and the bus held low.
        note(3'h4, 1'b0, 1'b1);
        note(3'h1, 1'b0, 1'b0);
        note(3'h2, 1'b0, 1'b1);
        note(3'h3, 1'b1, 1'b1);
        note(3'h1, 1'b0, 1'b1);
        note(3'h2, 1'b1, 1'b1);
        host_req <= 2'h3;
        cyc(4);
        ignition_wake_input <= 1'b1;
        cyc(ign_c + 3);
        {host_req, bus_level} <= 3'h2;
        cyc(bus_c + 3);
        host_req <= 2'h2;
        cyc(4);
        bus_level <= 1'b1;
        cyc(4);
        {host_req, ignition_wake_input} <= 3'h2;
        cyc(4);
        // Battery drop in silent restarts the reset pulse; a regulator fault in normal does too.
        note(3'h3, 1'b1, 1'b1);
        note(3'h1, 1'b1, 1'b1);
        note(3'h2, 1'b1, 1'b1);
        note(3'h1, 1'b1, 1'b1);
        note(3'h2, 1'b1, 1'b1);
        host_req <= 2'h2;
        cyc(4);
        battery_supply_ok <= 1'b0;
        cyc(1);
        {battery_supply_ok, host_req} <= 3'h5;
        cyc(3);
        @(negedge clock);
        chk("uv reset", 5'h04, {mode_out, reset_out_n, 1'b0});
        cyc(rst_c + 5);
        vcc_undervoltage <= 1'b1;
        cyc(3);
        vcc_undervoltage <= 1'b0;
        cyc(rst_c + 8);
        chk("left", 5'h00, 5'(exp_q.size()));
        complete_run;
    end
endmodule // tb_lnm_mode_ctrl
